// ==== hw/serial_eeprom_two_wire_slave.sv ====
// Write buffer and protocol engine of the two-wire serial EEPROM slave

// ========================================
// Write buffer
module wr_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PTR_W = $clog2(DEPTH);

    // Pointers wrap naturally, so DEPTH must be a power of two
    typedef struct packed {
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W:0]   count;
    } fifo_s;

    fifo_s            q;
    fifo_s            next_q;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    assign inReady  = q.count != (PTR_W+1)'(DEPTH);
    assign outValid = q.count != '0;
    assign outData  = store[q.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_q = q;
        if (flush) begin
            next_q = '0;
        end else begin
            if (push) begin
                next_q.wrPtr = q.wrPtr + 1'b1;
            end
            if (pop) begin
                next_q.rdPtr = q.rdPtr + 1'b1;
            end
            if (push && !pop) begin
                next_q.count = q.count + 1'b1;
            end else if (pop && !push) begin
                next_q.count = q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (push && !flush) begin
            store[q.wrPtr] <= inData;
        end
    end

endmodule : wr_fifo

module serial_eeprom_two_wire_slave
    import eeprom_pkg::*;
#(
    parameter int TWR_CYCLES_P = TWR_CYCLES,
    parameter int BUF_DEPTH    = FIFO_DEPTH
) (
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               scl,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaOe,
    input  wire logic               wp,
    input  wire logic [STRAP_W-1:0] chipSelectStraps,
    output logic                    standby
);
    localparam int TMR_W = $clog2(TWR_CYCLES_P + 1);
    localparam int ENT_W = ADDR_W + BYTE_W;

    // ========================================
    // State
    typedef struct packed {
        logic               sclMeta;
        logic               sclSync;
        logic               sclPrev;
        logic               sdaMeta;
        logic               sdaSync;
        logic               sdaPrev;
        logic               wpMeta;
        logic               wpSync;
        logic [STRAP_W-1:0] strapMeta;
        logic [STRAP_W-1:0] strapSync;
        link_state_e        state;
        logic [3:0]         bitCnt;
        logic [BYTE_W-1:0]  shiftReg;
        logic [ADDR_W-1:0]  addr;
        logic               isRead;
        logic               masterAck;
        logic               gotData;
        logic               busy;
        logic [TMR_W-1:0]   timer;
        logic               sdaOe;
        logic               sdaLow;
        logic               standby;
    } eng_s;

    eng_s              q;
    eng_s              next_q;
    logic [BYTE_W-1:0] mem [MEM_BYTES];
    logic [BYTE_W-1:0] rdByte;
    wr_entry_s         fifoIn;
    wr_entry_s         fifoOut;
    logic              fifoInValid;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic              fifoFlush;
    logic              sclRise;
    logic              sclFall;
    logic              startCond;
    logic              stopCond;

    function automatic logic dev_match(
        input logic [BYTE_W-1:0]  word,
        input logic [STRAP_W-1:0] straps
    );
        dev_match = word[7:4] == DEV_TYPE && word[3:1] == straps;
    endfunction : dev_match

    // ========================================
    // Condition detection on the synchronised pins
    assign sclRise   = q.sclSync && !q.sclPrev;
    assign sclFall   = !q.sclSync && q.sclPrev;
    // Data moving under a high clock is never a bit
    assign startCond = q.sclSync && q.sclPrev && q.sdaPrev && !q.sdaSync;
    assign stopCond  = q.sclSync && q.sclPrev && !q.sdaPrev && q.sdaSync;

    assign rdByte         = mem[q.addr];
    assign fifoIn.addr    = q.addr;
    assign fifoIn.data    = q.shiftReg;
    assign fifoFlush      = startCond && !q.busy;

    // ========================================
    // Protocol engine
    always_comb begin
        next_q             = q;
        next_q.sclMeta     = scl;
        next_q.sclSync     = q.sclMeta;
        next_q.sclPrev     = q.sclSync;
        next_q.sdaMeta     = sdaIn;
        next_q.sdaSync     = q.sdaMeta;
        next_q.sdaPrev     = q.sdaSync;
        next_q.wpMeta      = wp;
        next_q.wpSync      = q.wpMeta;
        // Pads carry pull-downs, so a floating strap arrives as zero
        next_q.strapMeta   = chipSelectStraps;
        next_q.strapSync   = q.strapMeta;
        next_q.sdaLow      = 1'b0;
        fifoInValid        = 1'b0;
        if (q.busy) begin
            // Bus is deaf until the array is written and the time is up
            if (q.timer != '0) begin
                next_q.timer = q.timer - 1'b1;
            end else if (!fifoOutValid) begin
                next_q.busy = 1'b0;
            end
        end else if (startCond) begin
            // A repeated START drops any unfinished write
            next_q.state   = ST_DEVADDR;
            next_q.bitCnt  = BIT_ZERO;
            next_q.sdaOe   = 1'b0;
            next_q.gotData = 1'b0;
        end else if (stopCond) begin
            next_q.state   = ST_IDLE;
            next_q.sdaOe   = 1'b0;
            next_q.gotData = 1'b0;
            if (q.state == ST_WRDATA && q.gotData) begin
                next_q.busy  = 1'b1;
                next_q.timer = TMR_W'(TWR_CYCLES_P - 1);
            end
        end else if (sclRise && q.state != ST_IDLE && q.state != ST_IGNORE) begin
            if (q.bitCnt < BIT_LAST && q.state != ST_RDDATA) begin
                next_q.shiftReg = {q.shiftReg[BYTE_W-2:0], q.sdaSync};
            end
            if (q.bitCnt == BIT_LAST && q.state == ST_RDDATA) begin
                next_q.masterAck = !q.sdaSync;
            end
            if (q.bitCnt < BIT_ACK) begin
                next_q.bitCnt = q.bitCnt + 1'b1;
            end
        end else if (sclFall) begin
            case (q.state)
                ST_DEVADDR: begin
                    if (q.bitCnt == BIT_LAST) begin
                        if (dev_match(q.shiftReg, q.strapSync)) begin
                            next_q.sdaOe  = 1'b1;
                            next_q.isRead = q.shiftReg[0];
                        end else begin
                            // A foreign word drops the engine straight back to standby
                            next_q.state = ST_IDLE;
                        end
                    end else if (q.bitCnt == BIT_ACK) begin
                        next_q.bitCnt = BIT_ZERO;
                        if (q.isRead) begin
                            next_q.state    = ST_RDDATA;
                            next_q.shiftReg = rdByte;
                            next_q.sdaOe    = !rdByte[BYTE_W-1];
                            next_q.addr     = q.addr + 1'b1;
                        end else begin
                            next_q.state = ST_ADDRHI;
                            next_q.sdaOe = 1'b0;
                        end
                    end
                end
                ST_ADDRHI: begin
                    if (q.bitCnt == BIT_LAST) begin
                        next_q.sdaOe = 1'b1;
                        // Top bit of the high word is ignored
                        next_q.addr[ADDR_W-1:BYTE_W] = q.shiftReg[ADDR_W-BYTE_W-1:0];
                    end else if (q.bitCnt == BIT_ACK) begin
                        next_q.sdaOe  = 1'b0;
                        next_q.bitCnt = BIT_ZERO;
                        next_q.state  = ST_ADDRLO;
                    end
                end
                ST_ADDRLO: begin
                    if (q.bitCnt == BIT_LAST) begin
                        next_q.sdaOe             = 1'b1;
                        next_q.addr[BYTE_W-1:0] = q.shiftReg;
                    end else if (q.bitCnt == BIT_ACK) begin
                        next_q.sdaOe  = 1'b0;
                        next_q.bitCnt = BIT_ZERO;
                        next_q.state  = ST_WRDATA;
                    end
                end
                ST_WRDATA: begin
                    // A full buffer refuses the byte with a missing ack
                    if (q.bitCnt == BIT_LAST && fifoInReady) begin
                        next_q.sdaOe = 1'b1;
                        fifoInValid  = !q.wpSync;
                        next_q.gotData = q.gotData || !q.wpSync;
                        next_q.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + 1'b1;
                    end else if (q.bitCnt == BIT_ACK) begin
                        next_q.sdaOe  = 1'b0;
                        next_q.bitCnt = BIT_ZERO;
                    end
                end
                ST_RDDATA: begin
                    if (q.bitCnt != BIT_ZERO && q.bitCnt < BIT_LAST) begin
                        next_q.shiftReg = {q.shiftReg[BYTE_W-2:0], 1'b0};
                        next_q.sdaOe    = !q.shiftReg[BYTE_W-2];
                    end else if (q.bitCnt == BIT_LAST) begin
                        next_q.sdaOe = 1'b0;
                    end else if (q.bitCnt == BIT_ACK) begin
                        next_q.bitCnt = BIT_ZERO;
                        if (q.masterAck) begin
                            next_q.shiftReg = rdByte;
                            next_q.sdaOe    = !rdByte[BYTE_W-1];
                            next_q.addr     = q.addr + 1'b1;
                        end else begin
                            next_q.state = ST_IGNORE;
                        end
                    end
                end
                default: begin
                    next_q.sdaOe = 1'b0;
                end
            endcase
        end
        next_q.standby = next_q.state == ST_IDLE && !next_q.busy;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q          <= '0;
            q.sclMeta  <= 1'b1;
            q.sclSync  <= 1'b1;
            q.sclPrev  <= 1'b1;
            q.sdaMeta  <= 1'b1;
            q.sdaSync  <= 1'b1;
            q.sdaPrev  <= 1'b1;
            q.state    <= ST_IDLE;
            q.addr     <= ADDR_RESET;
            q.standby  <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Array has no reset: contents survive like the cells
    always_ff @(posedge mclk) begin
        if (q.busy && fifoOutValid) begin
            mem[fifoOut.addr] <= fifoOut.data;
        end
    end

    // ========================================
    // Write buffer, drained only inside the write cycle
    wr_fifo #(
        .WIDTH (ENT_W),
        .DEPTH (BUF_DEPTH)
    ) u_wr_fifo (
        .mclk     (mclk),
        .nrst     (nrst),
        .flush    (fifoFlush),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (q.busy),
        .outData  (fifoOut)
    );

    assign sdaOut  = q.sdaLow;
    assign sdaOe   = q.sdaOe;
    assign standby = q.standby;

    // ========================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_devWordDone;
        q.state == ST_DEVADDR && sclFall && q.bitCnt == BIT_LAST && !q.busy;
    endsequence

    sequence s_readAckFall;
        q.state == ST_RDDATA && sclFall && q.bitCnt == BIT_ACK && !q.busy;
    endsequence

    property p_devAck;
        s_devWordDone ##0 dev_match(q.shiftReg, q.strapSync)
            |=> q.sdaOe && q.isRead == $past(q.shiftReg[0]);
    endproperty
    a_devAck: assert property (p_devAck) else $error("no ack on address match");

    property p_devNack;
        s_devWordDone ##0 !dev_match(q.shiftReg, q.strapSync)
            |=> !q.sdaOe && q.state == ST_IDLE && q.standby;
    endproperty
    a_devNack: assert property (p_devNack) else $error("ack on mismatch");

    property p_busyQuiet;
        q.busy |-> !q.sdaOe && q.state == ST_IDLE && !q.standby;
    endproperty
    a_busyQuiet: assert property (p_busyQuiet) else $error("bus served while busy");

    property p_protect;
        fifoInValid |-> !q.wpSync && q.state == ST_WRDATA;
    endproperty
    a_protect: assert property (p_protect) else $error("write while protected");

    property p_pageWrap;
        q.state == ST_WRDATA && sclFall && q.bitCnt == BIT_LAST && fifoInReady && !q.busy
            |=> q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W])
                && q.addr[PAGE_W-1:0] == $past(q.addr[PAGE_W-1:0]) + 6'h01;
    endproperty
    a_pageWrap: assert property (p_pageWrap) else $error("page address step wrong");

    property p_writeStop;
        q.state == ST_WRDATA && q.gotData && stopCond && !q.busy
            |=> q.busy && !q.standby ##1 q.busy;
    endproperty
    a_writeStop: assert property (p_writeStop) else $error("stop did not start write");

    property p_readStop;
        (q.state == ST_RDDATA || q.state == ST_IGNORE) && stopCond && !q.busy
            |=> q.standby && !q.sdaOe;
    endproperty
    a_readStop: assert property (p_readStop) else $error("no standby after read");

    property p_start;
        startCond && !q.busy |=> q.state == ST_DEVADDR && q.bitCnt == BIT_ZERO && !q.sdaOe;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_sdaLowClock;
        $changed(q.sdaOe) |-> !q.sclSync;
    endproperty
    a_sdaLowClock: assert property (p_sdaLowClock) else $error("data moved, clock high");

    property p_readNext;
        s_readAckFall ##0 q.masterAck
            |=> q.sdaOe == !$past(rdByte[BYTE_W-1]) && q.addr == $past(q.addr) + 15'h0001;
    endproperty
    a_readNext: assert property (p_readNext) else $error("next read byte wrong");

    property p_readEnd;
        s_readAckFall ##0 !q.masterAck |=> q.state == ST_IGNORE && !q.sdaOe;
    endproperty
    a_readEnd: assert property (p_readEnd) else $error("read not ended");

endmodule : serial_eeprom_two_wire_slave

// ==== hw/eeprom_pkg.sv ====
// Constants, states and carriers of the two-wire serial EEPROM slave
package eeprom_pkg;

    // ========================================
    // Array geometry and word framing
    localparam int ADDR_W     = 15;
    localparam int PAGE_W     = 6;
    localparam int PAGE_COUNT = 512;
    localparam int MEM_BYTES  = PAGE_COUNT << PAGE_W;
    localparam int BYTE_W     = 8;
    localparam int STRAP_W    = 3;

    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK  = 4'h9;
    localparam logic [3:0] BIT_ZERO = 4'h0;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

    // ========================================
    // Timing
    localparam int CLK_MHZ    = 100;
    localparam int TWR_MS     = 5;
    localparam int TWR_CYCLES = TWR_MS * 1000 * CLK_MHZ;

    // ========================================
    // Write buffer
    localparam int FIFO_DEPTH = 32;

    // ========================================
    // Link states and carriers
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_DEVADDR = 7'h02,
        ST_ADDRHI  = 7'h04,
        ST_ADDRLO  = 7'h08,
        ST_WRDATA  = 7'h10,
        ST_RDDATA  = 7'h20,
        ST_IGNORE  = 7'h40
    } link_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } wr_entry_s;

endpackage : eeprom_pkg

// ==== test/bus_controller_model.sv ====
// Behavioural two-wire bus controller that drives the clock and pulls the data line
module bus_controller_model (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaLow
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // Idle bus: clock stands high, data released to its pull-up
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge mclk);
    endtask : waitc

    // Data moves mid-way through clock low and is sampled mid-way through clock high
    task automatic bitx(input logic v, output logic s);
        waitc(4);
        sdaLow = !v;
        waitc(4);
        scl = 1'b1;
        waitc(4);
        s = sda;
        waitc(4);
        scl = 1'b0;
    endtask : bitx

    task automatic start();
        waitc(4);
        sdaLow = 1'b0;
        waitc(4);
        scl = 1'b1;
        waitc(4);
        sdaLow = 1'b1;
        waitc(4);
        scl = 1'b0;
    endtask : start

    // Clock is left high afterwards, so it stands still between frames
    task automatic stop();
        waitc(4);
        sdaLow = 1'b1;
        waitc(4);
        scl = 1'b1;
        waitc(4);
        sdaLow = 1'b0;
        waitc(4);
    endtask : stop

    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], s);
        end
        bitx(1'b1, s);
        ack = !s;
    endtask : wrByte

    task automatic rdByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, s);
            b[i] = s;
        end
        bitx(!ackIt, s);
    endtask : rdByte
endmodule : bus_controller_model

// ==== test/serial_eeprom_two_wire_slave_test.sv ====
// Self-checking bench of the two-wire serial EEPROM slave
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nMismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module serial_eeprom_two_wire_slave_test
    import eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TWR = 200;
    logic               mclk, nrst, wp, standby, sdaOut, sdaOe, scl, ctlLow, ack;
    logic [STRAP_W-1:0] straps;
    logic [ADDR_W-1:0]  ctr, a;
    logic [7:0]         mem [int];
    int                 nMismatch, samplesChecked, cycles;
    int                 seed = 32'h91a43e6b;
    wire                sda = !((sdaOe && !sdaOut) || ctlLow);

    serial_eeprom_two_wire_slave #(.TWR_CYCLES_P(TWR), .BUF_DEPTH(128)) dut (
        .mclk(mclk), .nrst(nrst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .wp(wp), .chipSelectStraps(straps), .standby(standby));
    bus_controller_model ctl (.mclk(mclk), .sda(sda), .scl(scl), .sdaLow(ctlLow));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ========================================
    // Run control
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : giveVerdict

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            nMismatch++;
            giveVerdict();
        end
    end

    // ========================================
    // Transfers and reference model
    task automatic devWord(input logic rw, input logic [2:0] s, output logic k);
        ctl.start();
        ctl.wrByte({DEV_TYPE, s, rw}, k);
    endtask : devWord

    // Top bit of the high address word is random, since the device must ignore it
    task automatic setAddr(input logic [ADDR_W-1:0] ad);
        devWord(1'b0, straps, ack);
        `CHK("dev ack", 1'b1, ack)
        ctl.wrByte({1'($random(seed)), ad[14:8]}, ack);
        `CHK("hi ack", 1'b1, ack)
        ctl.wrByte(ad[7:0], ack);
        `CHK("lo ack", 1'b1, ack)
    endtask : setAddr

    task automatic writeSeq(input logic [ADDR_W-1:0] ad, input int n);
        logic [7:0] d;
        setAddr(ad);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            ctl.wrByte(d, ack);
            `CHK("data ack", 1'b1, ack)
            if (!wp) begin
                mem[int'({ad[14:6], 6'(ad[5:0] + i)})] = d;
            end
        end
        ctl.stop();
        repeat (3) @(negedge mclk);
        if (wp) begin
            `CHK("no write cycle", 1'b1, standby)
        end else begin
            `CHK("busy after stop", 1'b0, standby)
            devWord(1'b0, straps, ack);
            `CHK("poll busy", 1'b0, ack)
            ctl.stop();
            for (int k = 0; k < 3000 && !standby; k++) begin
                @(negedge mclk);
            end
            `CHK("standby after write", 1'b1, standby)
            devWord(1'b0, straps, ack);
            `CHK("poll ready", 1'b1, ack)
            ctl.stop();
        end
    endtask : writeSeq

    task automatic readSeq(input int n);
        logic [7:0] d;
        devWord(1'b1, straps, ack);
        `CHK("read dev ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            ctl.rdByte(i != n - 1, d);
            `CHK("read data", mem[int'(ctr)], d)
            ctr = ctr + 15'h0001;
        end
        ctl.stop();
        repeat (2) @(negedge mclk);
        `CHK("standby after read", 1'b1, standby)
    endtask : readSeq

    task automatic readAt(input logic [ADDR_W-1:0] ad, input int n);
        setAddr(ad);
        ctr = ad;
        readSeq(n);
    endtask : readAt

    // ========================================
    // Scenarios
    initial begin
        nrst = 1'b0;
        wp = 1'b0;
        straps = 3'($random(seed));
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("standby at power-up", 1'b1, standby)
        `CHK("sda out level", 1'b0, sdaOut)
        a = 15'($random(seed));
        writeSeq(a, 1);
        readAt(a, 1);
        $display("test byte write done");
        writeSeq({a[14:6], 6'h3e}, 66);
        readAt({a[14:6], 6'h00}, 64);
        $display("test page wrap done");
        writeSeq(15'h7ffe, 2);
        writeSeq(15'h0000, 2);
        readAt(15'h7ffe, 3);
        readSeq(1);
        $display("test read wrap done");
        for (int s = 0; s < 8; s++) begin
            if (3'(s) != straps) begin
                devWord(1'b0, 3'(s), ack);
                `CHK("foreign ack", 1'b0, ack)
                `CHK("foreign standby", 1'b1, standby)
                ctl.stop();
            end
        end
        $display("test address match done");
        wp = 1'b1;
        writeSeq(a, 1);
        readAt(a, 1);
        wp = 1'b0;
        $display("test write protect done");
        giveVerdict();
    end
endmodule : serial_eeprom_two_wire_slave_test
